/* File: shared/sac_pkg.sv */
// smram access control: shared constants for offsets, fields and reset values.
// assumes an 8-bit configuration port and a single 40 MHz clock domain.
`default_nettype none
package sac_pkg;
    // ------------------------------------------------------------
    // configuration space offsets
    // ------------------------------------------------------------
    localparam logic [7:0] SAC_OFS_CTRL = 8'h72; // smram_control
    localparam logic [7:0] SAC_OFS_EXT = 8'h73; // extended smram control
    // ------------------------------------------------------------
    // smram_control field positions
    // ------------------------------------------------------------
    localparam int SAC_B_VISIBLE = 6; // smm_space_visible
    localparam int SAC_B_LOCK = 4; // smm_space_lockdown
    localparam int SAC_B_GEN = 3; // global_smram_enable
    localparam logic [2:0] SAC_BASE_SEG = 3'h2; // compat_smm_base_segment, fixed 010
    localparam logic [7:0] SAC_CTRL_RST = 8'h02; // value after reset
    // ------------------------------------------------------------
    // extended control field positions and reset value
    // ------------------------------------------------------------
    localparam int SAC_B_HSEL = 7; // high_smram_select
    localparam int SAC_B_TSZ_HI = 2; // tseg_size msb
    localparam int SAC_B_TSZ_LO = 1; // tseg_size lsb
    localparam int SAC_B_TSEN = 0; // tseg_enable
    localparam logic [7:0] SAC_EXT_RST = 8'h3F; // value after reset
    localparam logic [7:0] SAC_EXT_RO1 = 8'h38; // cache policy bits, always one
    // ------------------------------------------------------------
    // compatible window a0000h..bffffh: address bits 19:17 equal 101
    // ------------------------------------------------------------
    localparam logic [2:0] SAC_COMPAT_TOP = 3'h5;
endpackage : sac_pkg
`default_nettype wire

/* File: shared/sac_steer_if.sv */
// smram access control: carrier between the register side and the decoder.
// assumes both ends sit on mclk; the decoder is purely combinational.
`default_nettype none
interface sac_steer_if;
    logic gen; // global_smram_enable
    logic visible; // smm_space_visible
    logic lock; // smm_space_lockdown
    logic hsel; // high_smram_select
    logic tseg_en; // tseg_enable
    logic smm; // processor in smm decode
    logic compat_hit; // address in compatible window
    logic high_hit; // address in extended window
    logic to_dram; // decision: steer to dram
    modport ctrl (output gen, visible, lock, hsel, tseg_en, smm, compat_hit, high_hit,
                  input to_dram);
    modport dec (input gen, visible, lock, hsel, tseg_en, smm, compat_hit, high_hit,
                 output to_dram);
endinterface : sac_steer_if
`default_nettype wire

/* File: verilog/sac_steer.sv */
// smram access control: steering decision for one memory access.
// assumes the window hits are decoded by the caller on the same clock.
`default_nettype none
module sac_steer (
    sac_steer_if.dec s
);
    // ------------------------------------------------------------
    // decision
    // ------------------------------------------------------------
    logic see; // smm space may be seen by this access
    logic compat_on; // compatible region active
    logic high_on; // extended region active
    always_comb begin
        // open only counts while enabled and unlocked; smm decode always sees it
        see = s.smm | (s.gen & s.visible & ~s.lock);
        // no smm memory at all without the global enable
        compat_on = s.gen & ~s.hsel;
        high_on = s.gen & s.hsel & s.tseg_en;
        // no remap: either dram at the same address or the pci bus
        s.to_dram = see & ((s.compat_hit & compat_on) | (s.high_hit & high_on));
    end
endmodule : sac_steer
`default_nettype wire

/* File: verilog/sac_top.sv */
// smram access control: smram_control and its lock, plus access steering.
// assumes nrst is the power-on reset and the memory path shares mclk.
//
// Function
// - open works only when enabled; lock works either way
// - open unlocked space visible outside smm
// - lock forces open low, freezes it
// - lock freezes itself and extended fields
// - lock set by write, cleared by reset
// - enable without high gives compat a0000h
// - enable low disables all smm memory
// - enable high: location from high, tseg
// - global enable frozen once locked
// - base segment reads fixed 010
// - no remap; dram or pci bus
// - high select forwards compat window pci
`default_nettype none
module sac_top
    import sac_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    output logic cfg_rvalid,
    input wire logic acc_valid,
    input wire logic [19:0] acc_addr,
    input wire logic acc_high_hit,
    input wire logic acc_smm,
    output logic route_valid,
    output logic route_dram,
    output logic route_pci
);
    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic gen_q, gen_d; // global_smram_enable
    logic vis_q, vis_d; // smm_space_visible
    logic lock_q, lock_d; // smm_space_lockdown
    logic hsel_q, hsel_d; // high_smram_select
    logic [1:0] tsz_q, tsz_d; // tseg_size
    logic tsen_q, tsen_d; // tseg_enable
    logic wr_ctrl; // write to smram_control
    logic wr_ext; // write to extended control
    logic [7:0] ctrl_rd; // smram_control as read
    logic [7:0] ext_rd; // extended control as read

    always_comb begin
        wr_ctrl = cfg_wr & (cfg_addr == SAC_OFS_CTRL);
        wr_ext = cfg_wr & (cfg_addr == SAC_OFS_EXT);
        gen_d = gen_q;
        vis_d = vis_q;
        lock_d = lock_q;
        hsel_d = hsel_q;
        tsz_d = tsz_q;
        tsen_d = tsen_q;
        // once locked, every write below is dropped
        if (wr_ctrl && !lock_q) begin
            gen_d = cfg_wdata[SAC_B_GEN];
            lock_d = cfg_wdata[SAC_B_LOCK];
            // the write that locks also closes the space, whatever bit 6 says
            vis_d = cfg_wdata[SAC_B_VISIBLE] & ~cfg_wdata[SAC_B_LOCK];
        end
        if (wr_ext && !lock_q) begin
            hsel_d = cfg_wdata[SAC_B_HSEL];
            tsz_d = cfg_wdata[SAC_B_TSZ_HI:SAC_B_TSZ_LO];
            tsen_d = cfg_wdata[SAC_B_TSEN];
        end
        // keeps open low while locked even if reached by other means
        if (lock_q) begin
            vis_d = 1'b0;
        end
    end

    // only power-on reset clears the lock; no write path can
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            gen_q <= SAC_CTRL_RST[SAC_B_GEN];
            vis_q <= SAC_CTRL_RST[SAC_B_VISIBLE];
            lock_q <= SAC_CTRL_RST[SAC_B_LOCK];
            hsel_q <= SAC_EXT_RST[SAC_B_HSEL];
            tsz_q <= SAC_EXT_RST[SAC_B_TSZ_HI:SAC_B_TSZ_LO];
            tsen_q <= SAC_EXT_RST[SAC_B_TSEN];
        end else begin
            gen_q <= gen_d;
            vis_q <= vis_d;
            lock_q <= lock_d;
            hsel_q <= hsel_d;
            tsz_q <= tsz_d;
            tsen_q <= tsen_d;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logic [7:0] rdata_d; // next read data
    logic rvalid_d; // next read strobe
    always_comb begin
        ctrl_rd = 8'h00; // reserved bits stay zero
        ctrl_rd[SAC_B_VISIBLE] = vis_q;
        ctrl_rd[SAC_B_LOCK] = lock_q;
        ctrl_rd[SAC_B_GEN] = gen_q;
        ctrl_rd[2:0] = SAC_BASE_SEG;
        ext_rd = SAC_EXT_RO1;
        ext_rd[SAC_B_HSEL] = hsel_q;
        ext_rd[SAC_B_TSZ_HI:SAC_B_TSZ_LO] = tsz_q;
        ext_rd[SAC_B_TSEN] = tsen_q;
        rvalid_d = cfg_rd;
        // unmapped offsets answer zero
        if (cfg_rd && cfg_addr == SAC_OFS_CTRL) begin
            rdata_d = ctrl_rd;
        end else if (cfg_rd && cfg_addr == SAC_OFS_EXT) begin
            rdata_d = ext_rd;
        end else begin
            rdata_d = 8'h00;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cfg_rdata <= 8'h00;
            cfg_rvalid <= 1'b0;
        end else begin
            cfg_rdata <= rdata_d;
            cfg_rvalid <= rvalid_d;
        end
    end

    // ------------------------------------------------------------
    // access steering
    // ------------------------------------------------------------
    sac_steer_if st ();
    assign st.gen = gen_q;
    assign st.visible = vis_q;
    assign st.lock = lock_q;
    assign st.hsel = hsel_q;
    assign st.tseg_en = tsen_q;
    assign st.smm = acc_smm;
    assign st.compat_hit = (acc_addr[19:17] == SAC_COMPAT_TOP);
    assign st.high_hit = acc_high_hit;

    sac_steer u_steer (
        .s(st)
    );

    // registered so the outputs come from flops; decision lags one cycle
    logic rv_d, rd_d, rp_d; // next route valid, dram, pci
    always_comb begin
        rv_d = acc_valid;
        rd_d = acc_valid & st.to_dram;
        rp_d = acc_valid & ~st.to_dram;
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            route_valid <= 1'b0;
            route_dram <= 1'b0;
            route_pci <= 1'b0;
        end else begin
            route_valid <= rv_d;
            route_dram <= rd_d;
            route_pci <= rp_d;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic compat_a; // access into the compatible window
    assign compat_a = acc_valid & (acc_addr[19:17] == SAC_COMPAT_TOP);

    sequence s_lock_write;
        wr_ctrl && !lock_q && cfg_wdata[SAC_B_LOCK];
    endsequence

    property p_lock_sticky;
        @(posedge mclk) disable iff (!nrst) s_lock_write ##1 1'b1 |-> lock_q [*8];
    endproperty
    a_lock_sticky: assert property (p_lock_sticky) else $error("lock cleared");

    property p_lock_closes;
        @(posedge mclk) disable iff (!nrst) lock_q |-> !vis_q && ctrl_rd[SAC_B_VISIBLE] == 1'b0;
    endproperty
    a_lock_closes: assert property (p_lock_closes) else $error("open while locked");

    property p_gen_frozen;
        @(posedge mclk) disable iff (!nrst) lock_q && cfg_wr |=> $stable(gen_q) && lock_q;
    endproperty
    a_gen_frozen: assert property (p_gen_frozen) else $error("enable changed");

    property p_ext_frozen;
        @(posedge mclk) disable iff (!nrst)
            lock_q |=> $stable(hsel_q) && $stable(tsz_q) && $stable(tsen_q);
    endproperty
    a_ext_frozen: assert property (p_ext_frozen) else $error("extended changed");

    property p_off_to_pci;
        @(posedge mclk) disable iff (!nrst) acc_valid && !gen_q |=> route_pci && !route_dram;
    endproperty
    a_off_to_pci: assert property (p_off_to_pci) else $error("dram while disabled");

    property p_open_sees;
        @(posedge mclk) disable iff (!nrst)
            compat_a && !acc_smm && gen_q && !hsel_q && vis_q && !lock_q |=> route_dram;
    endproperty
    a_open_sees: assert property (p_open_sees) else $error("open not visible");

    property p_compat_smm;
        @(posedge mclk) disable iff (!nrst)
            compat_a && acc_smm && gen_q && !hsel_q |=> route_valid && route_dram;
    endproperty
    a_compat_smm: assert property (p_compat_smm) else $error("compat not dram");

    property p_high_fwd;
        @(posedge mclk) disable iff (!nrst) compat_a && hsel_q |=> route_pci;
    endproperty
    a_high_fwd: assert property (p_high_fwd) else $error("compat not forwarded");

    property p_read_fixed;
        @(posedge mclk) disable iff (!nrst) cfg_rd && cfg_addr == SAC_OFS_CTRL |=>
            cfg_rvalid && cfg_rdata[2:0] == 3'h2 && !cfg_rdata[7] && !cfg_rdata[5];
    endproperty
    a_read_fixed: assert property (p_read_fixed) else $error("fixed bits wrong");

    property p_closed_no_smm;
        @(posedge mclk) disable iff (!nrst) compat_a && !acc_smm && !vis_q |=> !route_dram;
    endproperty
    a_closed_no_smm: assert property (p_closed_no_smm) else $error("leak outside smm");
endmodule : sac_top
`default_nettype wire

/* File: testbench/sac_cpu_model.sv */
// smram access control: model of the processor memory access path.
// assumes issue() is called just after a rising edge of mclk.
`default_nettype none
module sac_cpu_model (
    input wire logic mclk,
    output logic acc_valid,
    output logic [19:0] acc_addr,
    output logic acc_high_hit,
    output logic acc_smm,
    input wire logic route_valid,
    input wire logic route_dram,
    input wire logic route_pci
);
    timeunit 1ns;
    timeprecision 1ps;
    // --------------------------------------------------------
    // idle lines
    // --------------------------------------------------------
    initial begin
        acc_valid = 1'b0;
        acc_addr = 20'h00000;
        acc_high_hit = 1'b0;
        acc_smm = 1'b0;
    end
    // --------------------------------------------------------
    // one access, then one idle cycle before the next strobe
    // --------------------------------------------------------
    // outside an access the address shows its inverse, so a stale hit cannot pass
    task automatic issue(input logic [19:0] a, input logic hit, input logic smm,
                         output logic dram);
        acc_valid = 1'b1;
        acc_addr = a;
        acc_high_hit = hit;
        acc_smm = smm;
        @(posedge mclk);
        #1;
        acc_valid = 1'b0;
        acc_addr = ~a;
        acc_high_hit = ~hit;
        // x unless exactly one of dram and pci comes with valid
        dram = (route_valid === 1'b1 && route_dram === ~route_pci) ? route_dram : 1'bx;
        @(posedge mclk);
        #1;
    endtask : issue
endmodule : sac_cpu_model
`default_nettype wire

/* File: testbench/sac_top_tb.sv */
// smram access control: self-checking bench driving config and access ports.
// assumes sac_top and sac_cpu_model are compiled first.
`default_nettype none
module sac_top_tb
    import sac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, nrst, cfg_wr, cfg_rd, cfg_rvalid; // clock, reset, strobes
    logic [7:0] cfg_addr, cfg_wdata, cfg_rdata; // config port
    logic acc_valid, acc_high_hit, acc_smm; // access request
    logic [19:0] acc_addr; // access address
    logic route_valid, route_dram, route_pci; // steering answer
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;
    sac_top u_dut (.mclk(mclk), .nrst(nrst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_rvalid(cfg_rvalid), .acc_valid(acc_valid), .acc_addr(acc_addr),
        .acc_high_hit(acc_high_hit), .acc_smm(acc_smm), .route_valid(route_valid),
        .route_dram(route_dram), .route_pci(route_pci));
    sac_cpu_model u_cpu (.mclk(mclk), .acc_valid(acc_valid), .acc_addr(acc_addr),
        .acc_high_hit(acc_high_hit), .acc_smm(acc_smm), .route_valid(route_valid),
        .route_dram(route_dram), .route_pci(route_pci));
    // --------------------------------------------------------
    // clock and hang guard
    // --------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // the whole run is some 80 cycles, so 2000 means a hang
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            n_mismatch++;
            conclude();
        end
    end
    // --------------------------------------------------------
    // tasks: each starts and ends 1 ns after a rising edge
    // --------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic do_reset();
        nrst = 1'b0;
        repeat (6) @(posedge mclk);
        #1;
        nrst = 1'b1;
        @(posedge mclk);
        #1;
    endtask : do_reset
    // idle cycle after each strobe keeps back-to-back calls legal
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_wdata = d;
        @(posedge mclk);
        #1;
        cfg_wr = 1'b0;
        @(posedge mclk);
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        cfg_rd = 1'b1;
        cfg_addr = a;
        @(posedge mclk);
        #1;
        cfg_rd = 1'b0;
        chk("cfg_rvalid", 8'h01, {7'h00, cfg_rvalid});
        chk("cfg_rdata", exp, cfg_rdata);
        @(posedge mclk);
        #1;
    endtask : rd
    task automatic acc(input logic [19:0] a, input logic hit, input logic smm,
                       input logic exp);
        logic dram;
        u_cpu.issue(a, hit, smm, dram);
        chk("route_dram", {7'h00, exp}, {7'h00, dram});
    endtask : acc
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude
    // --------------------------------------------------------
    // main sequence
    // --------------------------------------------------------
    initial begin
        nrst = 1'b0;
        {cfg_wr, cfg_rd, cfg_addr, cfg_wdata} = 18'h00000;
        do_reset();
        rd(SAC_OFS_CTRL, 8'h02);
        rd(SAC_OFS_EXT, 8'h3F);
        rd(8'h10, 8'h00);
        acc(20'hA0000, 1'b0, 1'b1, 1'b0);
        wr(SAC_OFS_CTRL, 8'h40);
        acc(20'hA0000, 1'b0, 1'b0, 1'b0);
        $display("reset and disabled test done");
        wr(SAC_OFS_CTRL, 8'h08);
        acc(20'hBFFFF, 1'b0, 1'b1, 1'b1);
        acc(20'hA0000, 1'b0, 1'b0, 1'b0);
        acc(20'hC0000, 1'b0, 1'b1, 1'b0);
        wr(SAC_OFS_CTRL, 8'hE8);
        rd(SAC_OFS_CTRL, 8'h4A);
        acc(20'hA0000, 1'b0, 1'b0, 1'b1);
        $display("compatible window test done");
        wr(SAC_OFS_EXT, 8'h81);
        rd(SAC_OFS_EXT, 8'hB9);
        acc(20'hA0000, 1'b0, 1'b1, 1'b0);
        acc(20'h10000, 1'b1, 1'b1, 1'b1);
        wr(SAC_OFS_EXT, 8'h80);
        acc(20'h10000, 1'b1, 1'b1, 1'b0);
        wr(SAC_OFS_EXT, 8'h07);
        $display("high select test done");
        wr(SAC_OFS_CTRL, 8'h08);
        wr(SAC_OFS_CTRL, 8'h18);
        rd(SAC_OFS_CTRL, 8'h1A);
        wr(SAC_OFS_CTRL, 8'h47);
        rd(SAC_OFS_CTRL, 8'h1A);
        wr(SAC_OFS_EXT, 8'h80);
        rd(SAC_OFS_EXT, 8'h3F);
        acc(20'hA0000, 1'b0, 1'b0, 1'b0);
        acc(20'hA0000, 1'b0, 1'b1, 1'b1);
        $display("lockdown test done");
        do_reset();
        rd(SAC_OFS_CTRL, 8'h02);
        // deliberate misorder: lock written while open is still set
        wr(SAC_OFS_CTRL, 8'h48);
        wr(SAC_OFS_CTRL, 8'h58);
        rd(SAC_OFS_CTRL, 8'h1A);
        acc(20'hA0000, 1'b0, 1'b0, 1'b0);
        $display("relock after reset test done");
        conclude();
    end
endmodule : sac_top_tb
`default_nettype wire
